// ==== design/gcb_pkg.sv ====
// Package with the offsets, reset values, types and helpers of the configuration bank.
package gcb_pkg;

   // ==========================================================================
   // Window geometry and the fixed base-address port
   // ==========================================================================
   // Size of the decoded window in bytes.
   localparam int WIN_BYTES = 64;
   // Number of address bits that select a byte inside the window.
   localparam int WIN_BITS = 6;
   // Fixed I/O location of the base-address register after reset.
   localparam logic [15:0] BASE_PORT = 16'h02ea;
   // Byte lane of the base port inside its aligned word.
   localparam int BASE_LANE = 2;

   // ==========================================================================
   // Register offsets inside the window
   // ==========================================================================
   localparam logic [5:0] OFF_WD_TIMEOUT = 6'h00;
   localparam logic [5:0] OFF_WD_CONFIG = 6'h02;
   localparam logic [5:0] OFF_WD_STATUS = 6'h04;
   localparam logic [5:0] OFF_TIMER_VALUE = 6'h08;
   localparam logic [5:0] OFF_TIMER_STATUS = 6'h0c;
   localparam logic [5:0] OFF_TIMER_CONFIG = 6'h0d;
   localparam logic [5:0] OFF_MAX_MULT = 6'h10;
   localparam logic [5:0] OFF_PLL_POWER = 6'h12;
   localparam logic [5:0] OFF_PLL3_CONFIG = 6'h18;
   localparam logic [5:0] OFF_CORE_CLK = 6'h1e;
   localparam logic [5:0] OFF_PIN_FUNC = 6'h30;
   localparam logic [5:0] OFF_MISC_CONFIG = 6'h34;
   localparam logic [5:0] OFF_INT_ROUTE = 6'h38;
   localparam logic [5:0] OFF_DEVICE_ID = 6'h3c;
   localparam logic [5:0] OFF_REVISION = 6'h3d;
   localparam logic [5:0] OFF_BASE_READ = 6'h3e;

   // ==========================================================================
   // Reset values of the writable registers
   // ==========================================================================
   localparam logic [15:0] RST_WD_TIMEOUT = 16'h0000;
   localparam logic [15:0] RST_WD_CONFIG = 16'h0000;
   localparam logic [7:0] RST_WD_STATUS = 8'h00;
   localparam logic [7:0] RST_TIMER_STATUS = 8'h00;
   localparam logic [7:0] RST_TIMER_CONFIG = 8'h00;
   localparam logic [7:0] RST_PLL_POWER = 8'h2f;
   localparam logic [31:0] RST_PLL3_CONFIG = 32'he1040005;
   localparam logic [31:0] RST_PIN_FUNC = 32'h00000000;
   localparam logic [31:0] RST_MISC_CONFIG = 32'h00000001;
   localparam logic [7:0] RST_INT_ROUTE = 8'h00;
   localparam logic [15:0] RST_BASE = 16'h0000;

   // ==========================================================================
   // Types
   // ==========================================================================
   // How a byte of the window behaves.
   typedef enum logic [1:0] {
      GCB_NONE = 2'b00,
      GCB_RW = 2'b01,
      GCB_W1C = 2'b11,
      GCB_RO = 2'b10
   } gcb_kind_t;

   // One I/O request from the core as seen on the internal bus.
   typedef struct packed {
      logic [15:0] addr;
      logic [3:0] byteEn;
      logic wr;
      logic rd;
      logic [31:0] wdata;
   } gcb_req_t;

   // Stored configuration handed to the functions the bank steers.
   typedef struct packed {
      logic [15:0] wdTimeout;
      logic [15:0] wdConfig;
      logic [7:0] timerStatus;
      logic [7:0] timerConfig;
      logic [7:0] pllPower;
      logic [31:0] pll3Config;
      logic [15:0] coreClkCtl;
      logic [31:0] pinFunc;
      logic [31:0] miscConfig;
      logic [7:0] intRoute;
   } gcb_cfg_t;

   // ==========================================================================
   // Per-byte attributes
   // ==========================================================================
   // Returns true when byte o lies in [base, base+len).
   // The sum is taken on seven bits, so a range ending at the window top does not wrap to zero.
   function automatic logic inRange(input logic [5:0] o, input logic [5:0] base,
                                    input logic [5:0] len);
      inRange = ({1'b0, o} >= {1'b0, base}) && ({1'b0, o} < {1'b0, base} + {1'b0, len});
   endfunction : inRange

   // Kind of each byte; everything not listed is a reserved hole.
   function automatic gcb_kind_t byteKind(input logic [5:0] o);
      if (inRange(o, OFF_WD_TIMEOUT, 6'h04) || inRange(o, OFF_TIMER_STATUS, 6'h02) ||
          o == OFF_PLL_POWER || inRange(o, OFF_PLL3_CONFIG, 6'h04) ||
          inRange(o, OFF_CORE_CLK, 6'h02) || inRange(o, OFF_PIN_FUNC, 6'h08) ||
          o == OFF_INT_ROUTE) begin
         byteKind = GCB_RW;
      end else if (o == OFF_WD_STATUS) begin
         byteKind = GCB_W1C;
      end else if (inRange(o, OFF_TIMER_VALUE, 6'h04) || o == OFF_MAX_MULT ||
                   inRange(o, OFF_DEVICE_ID, 6'h04)) begin
         byteKind = GCB_RO;
      end else begin
         byteKind = GCB_NONE;
      end
   endfunction : byteKind

   // Reset value of each stored byte.
   function automatic logic [7:0] byteReset(input logic [5:0] o);
      logic [511:0] img;
      img = '0;
      img[8*OFF_WD_TIMEOUT +: 16] = RST_WD_TIMEOUT;
      img[8*OFF_WD_CONFIG +: 16] = RST_WD_CONFIG;
      img[8*OFF_WD_STATUS +: 8] = RST_WD_STATUS;
      img[8*OFF_TIMER_STATUS +: 8] = RST_TIMER_STATUS;
      img[8*OFF_TIMER_CONFIG +: 8] = RST_TIMER_CONFIG;
      img[8*OFF_PLL_POWER +: 8] = RST_PLL_POWER;
      img[8*OFF_PLL3_CONFIG +: 32] = RST_PLL3_CONFIG;
      img[8*OFF_PIN_FUNC +: 32] = RST_PIN_FUNC;
      img[8*OFF_MISC_CONFIG +: 32] = RST_MISC_CONFIG;
      img[8*OFF_INT_ROUTE +: 8] = RST_INT_ROUTE;
      byteReset = img[8*o +: 8];
   endfunction : byteReset

endpackage : gcb_pkg

// ==== design/gcb_byte_reg.sv ====
// One stored byte of the configuration window, read/write or write-one-to-clear.
`timescale 1ns/1ps
module gcb_byte_reg #(
   parameter logic [7:0] RESET = 8'h00,
   parameter bit W1C = 1'b0
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic rstn,
   // Software write of this byte.
   input wire logic wrEn,
   input wire logic [7:0] wrData,
   // Hardware events that set bits (used in clear-on-one mode only).
   input wire logic [7:0] hwSet,
   // One-shot load of a value caught after reset.
   input wire logic load,
   input wire logic [7:0] loadVal,
   // Stored value.
   output logic [7:0] q
);

   // ==========================================================================
   // Next value
   // ==========================================================================
   logic [7:0] d;
   // In clear mode a write of one clears, and an event in the same cycle still sets.
   assign d = load ? loadVal :
              W1C ? ((q & ~(wrEn ? wrData : 8'h00)) | hwSet) :
              (wrEn ? wrData : q);

   // Storage; in read/write mode every bit, reserved or not, keeps what was written.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         q <= RESET;
      end else begin
         q <= d;
      end
   end

endmodule : gcb_byte_reg

// ==== design/gcb_config_bank.sv ====
// Address decode and register bank of the general configuration unit.
//
// Behaviour
// R01: Decode a 64-byte I/O window at programmed base.
// R02: No PCI configuration header; I/O decode only.
// R03: Base register answers at fixed 02EAh after reset.
// R04: Only first base write taken until reset.
// R05: Firmware programs base before any PCI access.
// R06: Reserved bits read back as last written.
// R07: Four interrupt sources merge onto one routed line.
// R08: Multiplier byte read-only, taken from straps.
// R09: Offset is address minus base; holes inert.
`timescale 1ns/1ps
module gcb_config_bank #(
   // Arbitrary identification values, chosen freely.
   parameter logic [7:0] DEVICE_ID = 8'h5a,
   parameter logic [7:0] REVISION = 8'h01
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic rstn,
   // I/O request from the core and its answer.
   input wire gcb_pkg::gcb_req_t req,
   output logic ack,
   output logic [31:0] rdata,
   // Straps and function state read through the window.
   input wire logic [7:0] maxMultStrap,
   input wire logic [15:0] coreClkStrap,
   input wire logic [31:0] timerValue,
   input wire logic [7:0] wdEvent,
   // Interrupt requests of the four functions and the merged line.
   input wire logic [3:0] irqReq,
   output logic irqLine,
   // Stored configuration.
   output gcb_pkg::gcb_cfg_t cfg,
   output logic [15:0] baseAddr,
   output logic baseValid
);

   // ==========================================================================
   // Base-address register
   // ==========================================================================
   logic [15:0] base_q;
   logic [15:0] base_d;
   logic baseLock_q;
   logic access;
   logic fixedHit;
   logic fixedWr;
   // Both halves of the base port share the aligned word at 02E8h.
   assign access = req.wr | req.rd;
   assign fixedHit = access && (req.addr[15:2] == gcb_pkg::BASE_PORT[15:2]); // [R03]
   assign fixedWr = fixedHit && req.wr && (req.byteEn[3:2] != 2'b00);
   // Only enabled lanes change; a later write is dropped while the lock stands.
   assign base_d = {req.byteEn[3] ? req.wdata[31:24] : base_q[15:8],
                    req.byteEn[2] ? req.wdata[23:16] : base_q[7:0]};

   // The lock is released only by reset, so the window cannot be moved twice.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         base_q <= gcb_pkg::RST_BASE;
         baseLock_q <= 1'b0;
      end else if (fixedWr && !baseLock_q) begin
         base_q <= base_d; // [R04]
         baseLock_q <= 1'b1; // [R04]
      end
   end

   // ==========================================================================
   // Window decode
   // ==========================================================================
   logic [15:0] baseAligned;
   logic [15:0] wordAddr;
   logic [15:0] diff;
   logic inWindow;
   logic [3:0] offWord;
   logic winWr;
   // The low six base bits are ignored so the window stays naturally aligned.
   assign baseAligned = {base_q[15:gcb_pkg::WIN_BITS], 6'h00};
   assign wordAddr = {req.addr[15:2], 2'b00};
   assign diff = wordAddr - baseAligned; // [R09]
   // No window address decodes before firmware has placed the window; only I/O space is claimed.
   assign inWindow = access && baseLock_q && (diff[15:gcb_pkg::WIN_BITS] == 10'h000)
                     && !fixedHit; // [R01] [R02] [R05]
   assign offWord = diff[5:2];
   assign winWr = inWindow && req.wr;

   // ==========================================================================
   // Strap capture for the core clock control reset value
   // ==========================================================================
   logic strapPend_q;
   // The strap is taken one cycle after release, never under reset itself.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         strapPend_q <= 1'b1;
      end else begin
         strapPend_q <= 1'b0;
      end
   end

   // ==========================================================================
   // Byte array of the window
   // ==========================================================================
   logic [7:0] stored [gcb_pkg::WIN_BYTES];
   logic [7:0] rdByte [gcb_pkg::WIN_BYTES];
   logic [511:0] storedFlat;

   for (genvar i = 0; i < gcb_pkg::WIN_BYTES; i++) begin : g_byte
      localparam logic [5:0] OFF = 6'(i);
      localparam gcb_pkg::gcb_kind_t KIND = gcb_pkg::byteKind(OFF);
      logic wrHere;
      // A write reaches a byte only when its word is selected and its lane enabled.
      assign wrHere = winWr && (offWord == OFF[5:2]) && req.byteEn[i % 4]; // [R09]
      assign storedFlat[8*i +: 8] = stored[i];
      if (KIND == gcb_pkg::GCB_RW || KIND == gcb_pkg::GCB_W1C) begin : g_store
         logic isClk;
         assign isClk = (OFF[5:1] == gcb_pkg::OFF_CORE_CLK[5:1]);
         gcb_byte_reg #(
            .RESET(gcb_pkg::byteReset(OFF)),
            .W1C(KIND == gcb_pkg::GCB_W1C)
         ) u_reg (
            .clk(clk),
            .rstn(rstn),
            .wrEn(wrHere), // [R06]
            .wrData(req.wdata[8*(i % 4) +: 8]),
            .hwSet((KIND == gcb_pkg::GCB_W1C) ? wdEvent : 8'h00),
            .load(isClk && strapPend_q),
            .loadVal(coreClkStrap[8*(i % 2) +: 8]),
            .q(stored[i])
         );
         assign rdByte[i] = stored[i];
      end else begin : g_nostore
         // Read-only bytes and holes keep nothing, so writes to them do nothing.
         assign stored[i] = 8'h00; // [R09]
         if (OFF >= gcb_pkg::OFF_TIMER_VALUE && OFF < gcb_pkg::OFF_TIMER_STATUS) begin : g_tmr
            assign rdByte[i] = timerValue[8*(i % 4) +: 8];
         end else if (OFF == gcb_pkg::OFF_MAX_MULT) begin : g_mult
            assign rdByte[i] = maxMultStrap; // [R08]
         end else if (OFF == gcb_pkg::OFF_DEVICE_ID) begin : g_id
            assign rdByte[i] = DEVICE_ID;
         end else if (OFF == gcb_pkg::OFF_REVISION) begin : g_rev
            assign rdByte[i] = REVISION;
         end else if (OFF[5:1] == gcb_pkg::OFF_BASE_READ[5:1]) begin : g_base
            assign rdByte[i] = base_q[8*(i % 2) +: 8];
         end else begin : g_hole
            assign rdByte[i] = 8'h00;
         end
      end
   end

   // ==========================================================================
   // Read mux and answer
   // ==========================================================================
   logic [31:0] winData;
   logic [31:0] readData;
   assign winData = {rdByte[{offWord, 2'b11}], rdByte[{offWord, 2'b10}],
                     rdByte[{offWord, 2'b01}], rdByte[{offWord, 2'b00}]};
   // The base port sits in the upper half of its word; the lower half reads zero.
   assign readData = fixedHit ? {base_q, 16'h0000} : (inWindow ? winData : 32'h00000000);

   // Claimed cycles answer one clock later; unclaimed ones get no answer at all.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         ack <= 1'b0;
         rdata <= 32'h00000000;
      end else begin
         ack <= fixedHit | inWindow; // [R01] [R03]
         rdata <= req.rd ? readData : 32'h00000000;
      end
   end

   // ==========================================================================
   // Interrupt merge and configuration outputs
   // ==========================================================================
   // The merged line is registered; its destination is the route byte in cfg.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         irqLine <= 1'b0;
      end else begin
         irqLine <= |irqReq; // [R07]
      end
   end

   assign cfg.wdTimeout = storedFlat[8*gcb_pkg::OFF_WD_TIMEOUT +: 16];
   assign cfg.wdConfig = storedFlat[8*gcb_pkg::OFF_WD_CONFIG +: 16];
   assign cfg.timerStatus = storedFlat[8*gcb_pkg::OFF_TIMER_STATUS +: 8];
   assign cfg.timerConfig = storedFlat[8*gcb_pkg::OFF_TIMER_CONFIG +: 8];
   assign cfg.pllPower = storedFlat[8*gcb_pkg::OFF_PLL_POWER +: 8];
   assign cfg.pll3Config = storedFlat[8*gcb_pkg::OFF_PLL3_CONFIG +: 32];
   assign cfg.coreClkCtl = storedFlat[8*gcb_pkg::OFF_CORE_CLK +: 16];
   assign cfg.pinFunc = storedFlat[8*gcb_pkg::OFF_PIN_FUNC +: 32];
   assign cfg.miscConfig = storedFlat[8*gcb_pkg::OFF_MISC_CONFIG +: 32];
   assign cfg.intRoute = storedFlat[8*gcb_pkg::OFF_INT_ROUTE +: 8]; // [R07]
   assign baseAddr = base_q;
   assign baseValid = baseLock_q;

   // ==========================================================================
   // Assertions
   // ==========================================================================
   a_base_once: assert property (@(posedge clk) disable iff (!rstn) // [R04]
      baseLock_q |=> $stable(base_q) && baseLock_q)
      else $error("base register changed after first write");

   a_base_first: assert property (@(posedge clk) disable iff (!rstn) // [R04]
      (fixedWr && !baseLock_q && req.byteEn[3:2] == 2'b11) |=>
      base_q == $past(req.wdata[31:16]))
      else $error("first base write not taken");

   a_fixed_answer: assert property (@(posedge clk) disable iff (!rstn) // [R03]
      (fixedHit && req.rd) |=> ack && rdata[31:16] == $past(base_q))
      else $error("fixed base port did not answer");

   a_window_ack: assert property (@(posedge clk) disable iff (!rstn) // [R01]
      (access && baseLock_q && !fixedHit && (wordAddr - baseAligned) < 16'h0040) |=> ack)
      else $error("window access not answered");

   a_outside_quiet: assert property (@(posedge clk) disable iff (!rstn) // [R01]
      (!fixedHit && (!baseLock_q || diff >= 16'h0040)) |=> !ack)
      else $error("access outside window answered");

   a_rw_readback: assert property (@(posedge clk) disable iff (!rstn) // [R06]
      (winWr && offWord == gcb_pkg::OFF_PIN_FUNC[5:2] && req.byteEn == 4'hf) |=>
      cfg.pinFunc == $past(req.wdata))
      else $error("written value not held");

   a_strap_read: assert property (@(posedge clk) disable iff (!rstn) // [R08]
      (inWindow && req.rd && offWord == gcb_pkg::OFF_MAX_MULT[5:2]) |=>
      rdata[7:0] == $past(maxMultStrap))
      else $error("multiplier byte not from straps");

   a_hole_inert: assert property (@(posedge clk) disable iff (!rstn) // [R09]
      (winWr && offWord == 4'h8) |=> $stable(storedFlat))
      else $error("write to a hole changed storage");

   a_irq_merge: assert property (@(posedge clk) disable iff (!rstn) // [R07]
      (irqReq != 4'h0) |=> irqLine)
      else $error("interrupt request not merged onto the line");

   a_irq_quiet: assert property (@(posedge clk) disable iff (!rstn) // [R07]
      (irqReq == 4'h0) |=> !irqLine)
      else $error("merged line raised without a request");

endmodule : gcb_config_bank

// ==== bench/gcb_core_model.sv ====
// Behavioural processor core that issues single I/O cycles to the configuration bank.
`timescale 1ns/1ps
module gcb_core_model (
   // Clock.
   input wire logic clk,
   // I/O request towards the bank and its answer.
   output gcb_pkg::gcb_req_t req,
   input wire logic ack,
   input wire logic [31:0] rdata
);
   // ==========================================================================
   // Bus cycles
   // ==========================================================================
   // Idle bus from time zero, so the bank never sees a floating strobe.
   initial begin
      req = '0;
   end

   // One access. The strobe stands for a single edge, because every edge with a strobe
   // counts as a new access. The answer is looked at in the cycle after that edge.
   task automatic ioCycle(input logic wr, input logic [15:0] addr, input logic [3:0] be,
                          input logic [31:0] wd, output logic gotAck, output logic [31:0] rd);
      @(posedge clk);
      req.addr <= addr;
      req.byteEn <= be;
      req.wr <= wr;
      req.rd <= ~wr;
      req.wdata <= wd;
      @(posedge clk);
      req.wr <= 1'b0;
      req.rd <= 1'b0;
      // Released qualifiers show the inverse, so a stale value can never pass for a live one.
      req.addr <= ~addr;
      req.byteEn <= ~be;
      req.wdata <= ~wd;
      // Let the answering edge settle before sampling.
      #1;
      gotAck = ack;
      rd = rdata;
   endtask : ioCycle
endmodule : gcb_core_model

// ==== bench/tb_top.sv ====
// Self-checking bench of the configuration bank: reset, base lock, window map and interrupt.
`timescale 1ns/1ps
module tb_top;
   // ==========================================================================
   // Signals and bench state
   // ==========================================================================
   localparam logic [7:0] ID_VAL = 8'h3c; // Arbitrary identification value.
   localparam logic [7:0] REV_VAL = 8'h07; // Arbitrary revision value.
   // Read/write bytes of the window as a bit map; byte 4 is the clear-on-one status.
   localparam logic [63:0] RW_MASK = 64'h01ff0000_cf04300f;
   localparam int W1C_OFF = 4;
   logic clk = 1'b0; // Bench clock, 4 ns period.
   logic rstn = 1'b0; // Synchronous reset, active low.
   logic [7:0] maxMultStrap = 8'h00;
   logic [15:0] coreClkStrap = 16'h0000;
   logic [31:0] timerValue = 32'h00000000;
   logic [7:0] wdEvent = 8'h00;
   logic [3:0] irqReq = 4'h0;
   gcb_pkg::gcb_req_t req;
   logic ack;
   logic [31:0] rdata;
   logic irqLine;
   gcb_pkg::gcb_cfg_t cfg;
   logic [15:0] baseAddr;
   logic baseValid;
   int bad_count = 0;
   int comparisons = 0;
   logic [31:0] seed = 32'h000101dc; // Fixed seed 66012 keeps every run identical.
   logic [7:0] img [64]; // Expected content of every stored byte.
   logic [15:0] base = 16'h0000; // Base that the bench has programmed.
   logic [31:0] r;

   // Free-running clock.
   always #2 clk = ~clk;

   gcb_config_bank #(.DEVICE_ID(ID_VAL), .REVISION(REV_VAL)) i_dut (.clk(clk), .rstn(rstn),
      .req(req), .ack(ack), .rdata(rdata), .maxMultStrap(maxMultStrap),
      .coreClkStrap(coreClkStrap), .timerValue(timerValue), .wdEvent(wdEvent),
      .irqReq(irqReq), .irqLine(irqLine), .cfg(cfg), .baseAddr(baseAddr),
      .baseValid(baseValid));
   gcb_core_model i_core (.clk(clk), .req(req), .ack(ack), .rdata(rdata));

   // ==========================================================================
   // Helpers
   // ==========================================================================
   // Xorshift generator.
   function logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      rnd = seed;
   endfunction : rnd

   // Compare of a word result.
   task automatic cmpWord(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask : cmpWord

   // Compare of a flag result.
   task automatic cmpBit(input string what, input logic exp, input logic got);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected %s: expected %b, seen %b", what, exp, got);
      end
   endtask : cmpBit

   // Prints the counts and the verdict, then ends the run.
   task automatic stop_test();
      $display("comparisons %0d, mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : stop_test

   // Image after reset; the core clock control byte pair follows its strap.
   task automatic resetImg();
      foreach (img[i]) begin
         img[i] = 8'h00;
      end
      img[18] = 8'h2f;
      {img[27], img[26], img[25], img[24]} = 32'he1040005;
      {img[31], img[30]} = coreClkStrap;
      img[52] = 8'h01;
   endtask : resetImg

   // Expected read value of one byte; holes read zero.
   function automatic logic [7:0] expByte(input int o);
      if (RW_MASK[o] || o == W1C_OFF) begin
         return img[o];
      end
      if (o >= 8 && o < 12) begin
         return timerValue[8*(o-8) +: 8];
      end
      case (o)
         16: return maxMultStrap;
         60: return ID_VAL;
         61: return REV_VAL;
         62: return base[7:0];
         63: return base[15:8];
         default: return 8'h00;
      endcase
   endfunction : expByte

   // One access through the core model; read data is only judged on reads.
   task automatic access(input logic wr, input logic [15:0] addr, input logic [3:0] be,
                         input logic [31:0] wd, input logic hit, input logic [31:0] exp);
      logic gotAck;
      logic [31:0] got;
      i_core.ioCycle(wr, addr, be, wd, gotAck, got);
      cmpBit("ack", hit, gotAck);
      if (!wr) begin
         cmpWord("rdata", hit ? exp : 32'h0, got);
      end
   endtask : access

   // Window write that also updates the image by byte kind.
   task automatic winWrite(input logic [5:0] off, input logic [3:0] be, input logic [31:0] wd);
      int o;
      access(1'b1, {base[15:6], off[5:2], 2'b00}, be, wd, 1'b1, 32'h0);
      for (int l = 0; l < 4; l++) begin
         o = {off[5:2], 2'b00} + l;
         if (be[l] && RW_MASK[o]) begin
            img[o] = wd[8*l +: 8];
         end else if (be[l] && o == W1C_OFF) begin
            img[o] = img[o] & ~wd[8*l +: 8];
         end
      end
   endtask : winWrite

   // Full-word window read against the image.
   task automatic winRead(input logic [5:0] off);
      logic [31:0] exp;
      for (int l = 0; l < 4; l++) begin
         exp[8*l +: 8] = expByte({off[5:2], 2'b00} + l);
      end
      access(1'b0, {base[15:6], off[5:2], 2'b00}, 4'hf, 32'h0, 1'b1, exp);
   endtask : winRead

   // ==========================================================================
   // Scenarios
   // ==========================================================================
   // A hang counts as a mismatch and ends the run.
   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      stop_test();
   end

   // Main sequence.
   initial begin
      @(posedge clk);
      r = rnd();
      maxMultStrap <= r[7:0];
      coreClkStrap <= r[31:16];
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      resetImg();
      @(posedge clk);
      #1;
      cmpBit("baseValid", 1'b0, baseValid);
      cmpWord("pll3Config", 32'he1040005, cfg.pll3Config);
      // The window is not decoded before the base is programmed.
      access(1'b0, 16'h043c, 4'hf, 32'h0, 1'b0, 32'h0);
      access(1'b0, 16'h02e8, 4'hf, 32'h0, 1'b1, 32'h0);
      base = 16'h0400;
      access(1'b1, 16'h02e8, 4'hc, {base, 16'h0000}, 1'b1, 32'h0);
      cmpWord("baseAddr", {16'h0, base}, {16'h0, baseAddr});
      cmpBit("baseValid", 1'b1, baseValid);
      // A second base write is acked but leaves the window where it is.
      access(1'b1, 16'h02e8, 4'hc, 32'h0800_0000, 1'b1, 32'h0);
      access(1'b0, 16'h02e8, 4'hf, 32'h0, 1'b1, {base, 16'h0000});
      for (int w = 0; w < 64; w += 4) begin
         winRead(6'(w));
      end
      access(1'b0, base + 16'h0040, 4'hf, 32'h0, 1'b0, 32'h0);
      access(1'b0, base - 16'h0004, 4'hf, 32'h0, 1'b0, 32'h0);
      // Random traffic over the whole window, holes and read-only bytes included.
      repeat (150) begin
         @(posedge clk);
         r = rnd();
         timerValue <= r;
         maxMultStrap <= r[15:8] ^ r[7:0];
         r = rnd();
         winWrite(r[5:0], r[9:6], rnd());
         winRead(r[5:0]);
      end
      cmpWord("pinFunc", {img[51], img[50], img[49], img[48]}, cfg.pinFunc);
      cmpWord("intRoute", {24'h0, img[56]}, {24'h0, cfg.intRoute});
      // Every stored field but the watchdog status also leaves on the cfg port, not only through the read path.
      cmpWord("wdRegs", {img[3], img[2], img[1], img[0]}, {cfg.wdConfig, cfg.wdTimeout});
      cmpWord("timerPll", {8'h00, img[18], img[13], img[12]},
              {8'h00, cfg.pllPower, cfg.timerConfig, cfg.timerStatus});
      cmpWord("pll3Config", {img[27], img[26], img[25], img[24]}, cfg.pll3Config);
      cmpWord("coreClkCtl", {16'h0, img[31], img[30]}, {16'h0, cfg.coreClkCtl});
      cmpWord("miscConfig", {img[55], img[54], img[53], img[52]}, cfg.miscConfig);
      // Status bits set by events, then cleared by writing ones.
      @(posedge clk);
      wdEvent <= 8'ha5;
      @(posedge clk);
      wdEvent <= 8'h00;
      img[W1C_OFF] = 8'ha5;
      winRead(6'h04);
      winWrite(6'h04, 4'h1, 32'h0000_0081);
      winRead(6'h04);
      // Each request alone reaches the merged line one cycle later.
      for (int i = 0; i < 5; i++) begin
         @(posedge clk);
         irqReq <= (i < 4) ? 4'(1 << i) : 4'h0;
         @(posedge clk);
         #1;
         cmpBit("irqLine", i < 4, irqLine);
      end
      // A reset in mid-run opens the base port for one more write.
      @(posedge clk);
      rstn <= 1'b0;
      r = rnd();
      coreClkStrap <= r[15:0];
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      resetImg();
      @(posedge clk);
      #1;
      cmpBit("baseValid", 1'b0, baseValid);
      base = 16'h0840;
      access(1'b1, 16'h02e8, 4'hc, {base, 16'h0000}, 1'b1, 32'h0);
      winRead(6'h3c);
      winRead(6'h1c);
      winRead(6'h10);
      stop_test();
   end
endmodule : tb_top
